// [intc_defines.svh]
`ifndef INTC_DEFINES_SVH
`define INTC_DEFINES_SVH
// Register byte addresses
`define ADDR_CPU_STATUS_WORD 12'h000
`define ADDR_CORE_CONTROL 12'h004
`define ADDR_INTERRUPT_CONTROL_ONE 12'h008
`define ADDR_INTERRUPT_CONTROL_TWO 12'h00C
`define ADDR_REQUEST_FLAGS_ZERO 12'h010
`define ADDR_REQUEST_FLAGS_ONE 12'h014
`define ADDR_REQUEST_FLAGS_TWO 12'h018
// Field positions
`define PRIO_LOW_MSB 7
`define PRIO_LOW_LSB 5
`define PRIO_TOP_BIT 3
`define NEST_DIS_BIT 15
`define ALT_VEC_BIT 15
`define TIMED_DIS_BIT 14
// Writable masks (unimplemented bits read 0)
`define STATUS_MASK 16'h00E0
`define ICON1_MASK 16'hFFDE
`define ICON1_CTRL_MASK 16'h8700
`define ICON2_MASK 16'h8007
`define FLAGS0_MASK 16'h3FEF
`define FLAGS1_MASK 16'h201F
`define FLAGS2_MASK 16'h0020
// Reset values
`define RESET_ZERO 16'h0000
// Priority level above which the top bit is set
`define PRIO_TOP_THRESHOLD 4'h7
`endif

// [intc_pkg.sv]
package intc_pkg;
	typedef enum logic [1:0] {apb_idle, apb_access} apb_phase_t;
	typedef logic [15:0] reg16_t;
endpackage

// [interrupt_priority_trap_flags.sv]
// Operation
// - CPU level is core-control bit 3 above status priority bits.
// - Top priority bit set blocks all user interrupts.
// - Nesting disable makes status priority bits read-only.
// - Top bit reads 1 above level 7, resets 0, software clear only.
// - Three-bit field is binary level; with top bit levels 8 and up.
// - Set accumulator A/B overflow flags on overflow traps.
// - Set accumulator A/B catastrophic flags on catastrophic traps.
// - Overflow traps gated by bits 10, 9; catastrophic by bit 8.
// - Set bad-shift flag on invalid shift math trap.
// - Set divide-zero flag on divide-by-zero math trap.
// - Set math, address and stack trap flags on matching trap.
// - Set oscillator failure flag at bit 1 on that trap.
// - Flag register zero holds thirteen request flags at bits 13..5 and 3..0.
// - Request flags read 1 once occurred, readable, writable, reset 0.
// - Unimplemented bits read 0 and ignore writes.
// - Flag register one: ext irq2 at 13, five flags at 4..0.
// - Nesting disable stops preemption of a running service.
// - Alternate vector control selects the alternate vector table.
// - Hardware sets request flags; only software clears them.
`timescale 1ns/1ps
`include "intc_defines.svh"
module interrupt_priority_trap_flags
	import intc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0] pstrb_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic [3:0] cpu_prio_load_i,
	input wire logic cpu_prio_load_valid_i,
	input wire logic acc_a_overflow_i,
	input wire logic acc_b_overflow_i,
	input wire logic acc_a_catastrophic_i,
	input wire logic acc_b_catastrophic_i,
	input wire logic bad_shift_i,
	input wire logic divide_zero_i,
	input wire logic address_error_i,
	input wire logic stack_error_i,
	input wire logic osc_fail_i,
	input wire logic timed_disable_i,
	input wire logic service_active_i,
	input wire logic [2:0] ext_irq_pin_i,
	input wire logic [15:0] req_set_zero_i,
	input wire logic [15:0] req_set_one_i,
	input wire logic [15:0] req_set_two_i,
	output logic [3:0] cpu_prio_level_o,
	output logic user_irq_block_o,
	output logic preempt_allow_o,
	output logic alternate_vector_select_o,
	output logic acc_a_trap_o,
	output logic acc_b_trap_o,
	output logic catastrophic_trap_o
);
	reg16_t cpu_status_word;
	logic cpu_prio_top_bit;
	reg16_t interrupt_control_one;
	logic alternate_vector_select;
	logic timed_disable_active;
	logic [2:0] ext_irq_edge_select;
	reg16_t request_flags_zero;
	reg16_t request_flags_one;
	reg16_t request_flags_two;
	logic [2:0] pin_s1;
	logic [2:0] pin_s2;
	logic [2:0] pin_s3;
	logic [2:0] pin_level;
	logic [2:0] ext_edge;
	logic wr_en;
	logic rd_en;
	logic addr_hit;
	logic [15:0] wmask;
	reg16_t wdata;
	reg16_t next_rdata;
	logic nesting_disable;
	logic [3:0] cpu_level;
	logic trap_a;
	logic trap_b;
	logic trap_cat_a;
	logic trap_cat_b;

	assign wmask = {{8{pstrb_i[1]}}, {8{pstrb_i[0]}}};
	assign wdata = pwdata_i[15:0];
	assign wr_en = psel_i && penable_i && pwrite_i && pready_o;
	assign rd_en = psel_i && !penable_i && !pwrite_i;
	assign nesting_disable = interrupt_control_one[`NEST_DIS_BIT];
	assign cpu_level = {cpu_prio_top_bit, cpu_status_word[`PRIO_LOW_MSB:`PRIO_LOW_LSB]};
	assign trap_a = acc_a_overflow_i && interrupt_control_one[10];
	assign trap_b = acc_b_overflow_i && interrupt_control_one[9];
	assign trap_cat_a = acc_a_catastrophic_i && interrupt_control_one[8];
	assign trap_cat_b = acc_b_catastrophic_i && interrupt_control_one[8];

	always_comb
	begin
		addr_hit = 1'b1;
		next_rdata = 16'h0000;
		unique case (paddr_i)
			`ADDR_CPU_STATUS_WORD: next_rdata = cpu_status_word;
			`ADDR_CORE_CONTROL: next_rdata = {12'h000, cpu_prio_top_bit, 3'h0};
			`ADDR_INTERRUPT_CONTROL_ONE: next_rdata = interrupt_control_one;
			`ADDR_INTERRUPT_CONTROL_TWO: next_rdata = {alternate_vector_select,
				timed_disable_active, 11'h000, ext_irq_edge_select};
			`ADDR_REQUEST_FLAGS_ZERO: next_rdata = request_flags_zero;
			`ADDR_REQUEST_FLAGS_ONE: next_rdata = request_flags_one;
			`ADDR_REQUEST_FLAGS_TWO: next_rdata = request_flags_two;
			default: addr_hit = 1'b0;
		endcase
	end

	// APB slave: no wait states, read data captured in setup
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
		end
		else
		begin
			pready_o <= psel_i && !penable_i;
			pslverr_o <= psel_i && !penable_i && !addr_hit;
		end
	end

	// Read data holds until the next read setup
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			prdata_o <= 32'h00000000;
		else if (rd_en)
			prdata_o <= {16'h0000, next_rdata};
	end

	// Pin synchroniser, three stages
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			pin_s1 <= 3'h0;
			pin_s2 <= 3'h0;
			pin_s3 <= 3'h0;
			pin_level <= 3'h0;
		end
		else
		begin
			pin_s1 <= ext_irq_pin_i;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			// Level moves once stages two and three agree
			for (int i = 0; i < 3; i++)
				if (pin_s2[i] == pin_s3[i])
					pin_level[i] <= pin_s3[i];
		end
	end

	always_comb
	begin
		for (int i = 0; i < 3; i++)
			ext_edge[i] = (pin_s2[i] == pin_s3[i]) && (pin_s3[i] != pin_level[i])
				&& (pin_s3[i] ^ ext_irq_edge_select[i]);
	end

	// Status word priority field
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			cpu_status_word <= `RESET_ZERO;
		else if (cpu_prio_load_valid_i)
			cpu_status_word[`PRIO_LOW_MSB:`PRIO_LOW_LSB] <= cpu_prio_load_i[2:0];
		else if (wr_en && paddr_i == `ADDR_CPU_STATUS_WORD && !nesting_disable)
			cpu_status_word <= (cpu_status_word & ~(wmask & `STATUS_MASK))
				| (wdata & wmask & `STATUS_MASK);
	end

	// top bit loaded by core, software can only clear it
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			cpu_prio_top_bit <= 1'b0;
		else if (cpu_prio_load_valid_i)
			cpu_prio_top_bit <= cpu_prio_load_i[3];
		else if (wr_en && paddr_i == `ADDR_CORE_CONTROL && pstrb_i[0]
			&& !wdata[`PRIO_TOP_BIT])
			cpu_prio_top_bit <= 1'b0;
	end

	// Trap flags and enables; set wins over clear
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			interrupt_control_one <= `RESET_ZERO;
		else
		begin
			if (wr_en && paddr_i == `ADDR_INTERRUPT_CONTROL_ONE)
				interrupt_control_one <= (interrupt_control_one & ~(wmask & `ICON1_MASK))
					| (wdata & wmask & `ICON1_MASK);
			if (trap_a)
				interrupt_control_one[14] <= 1'b1;
			if (trap_b)
				interrupt_control_one[13] <= 1'b1;
			if (trap_cat_a)
				interrupt_control_one[12] <= 1'b1;
			if (trap_cat_b)
				interrupt_control_one[11] <= 1'b1;
			if (bad_shift_i)
				interrupt_control_one[7] <= 1'b1;
			if (divide_zero_i)
				interrupt_control_one[6] <= 1'b1;
			if (trap_a || trap_b || trap_cat_a || trap_cat_b || bad_shift_i
				|| divide_zero_i)
				interrupt_control_one[4] <= 1'b1;
			if (address_error_i)
				interrupt_control_one[3] <= 1'b1;
			if (stack_error_i)
				interrupt_control_one[2] <= 1'b1;
			if (osc_fail_i)
				interrupt_control_one[1] <= 1'b1;
		end
	end

	// Second control register
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			alternate_vector_select <= 1'b0;
			ext_irq_edge_select <= 3'h0;
			timed_disable_active <= 1'b0;
		end
		else
		begin
			// Status follows the core every cycle
			timed_disable_active <= timed_disable_i;
			if (wr_en && paddr_i == `ADDR_INTERRUPT_CONTROL_TWO)
			begin
				if (pstrb_i[1])
					alternate_vector_select <= wdata[`ALT_VEC_BIT];
				if (pstrb_i[0])
					ext_irq_edge_select <= wdata[2:0];
			end
		end
	end

	// request flags set by sources, cleared by software
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			request_flags_zero <= `RESET_ZERO;
			request_flags_one <= `RESET_ZERO;
			request_flags_two <= `RESET_ZERO;
		end
		else
		begin
			request_flags_zero <= (((wr_en && paddr_i == `ADDR_REQUEST_FLAGS_ZERO)
				? ((request_flags_zero & ~wmask) | (wdata & wmask)) : request_flags_zero)
				| req_set_zero_i | {15'h0000, ext_edge[0]}) & `FLAGS0_MASK;
			request_flags_one <= (((wr_en && paddr_i == `ADDR_REQUEST_FLAGS_ONE)
				? ((request_flags_one & ~wmask) | (wdata & wmask)) : request_flags_one)
				| req_set_one_i | {2'h0, ext_edge[2], 8'h00, ext_edge[1], 4'h0})
				& `FLAGS1_MASK;
			// Capture one flag only
			request_flags_two <= (((wr_en && paddr_i == `ADDR_REQUEST_FLAGS_TWO)
				? ((request_flags_two & ~wmask) | (wdata & wmask)) : request_flags_two)
				| req_set_two_i) & `FLAGS2_MASK;
		end
	end

	// Registered priority level to core
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			cpu_prio_level_o <= 4'h0;
			user_irq_block_o <= 1'b0;
		end
		else
		begin
			cpu_prio_level_o <= cpu_level;
			user_irq_block_o <= cpu_prio_top_bit || (cpu_level > `PRIO_TOP_THRESHOLD);
		end
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			preempt_allow_o <= 1'b1;
		else
			preempt_allow_o <= !(nesting_disable && service_active_i);
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			alternate_vector_select_o <= 1'b0;
		else
			alternate_vector_select_o <= alternate_vector_select;
	end

	// Enabled trap causes, one cycle late
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			acc_a_trap_o <= 1'b0;
			acc_b_trap_o <= 1'b0;
			catastrophic_trap_o <= 1'b0;
		end
		else
		begin
			acc_a_trap_o <= trap_a;
			acc_b_trap_o <= trap_b;
			catastrophic_trap_o <= trap_cat_a || trap_cat_b;
		end
	end
endmodule

// [trap_source_model.sv]
`timescale 1ns/1ps
module trap_source_model
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic fire_i,
	input wire logic [3:0] cause_i,
	output logic [8:0] trap_o
);
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			trap_o <= 9'h000;
		else
			trap_o <= fire_i ? (9'h001 << cause_i) : 9'h000;
	end
endmodule

// [interrupt_priority_trap_flags_properties.sv]
`timescale 1ns/1ps
module intc_checker
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic [3:0] cpu_prio_load_i,
	input wire logic cpu_prio_load_valid_i,
	input wire logic acc_a_overflow_i,
	input wire logic acc_a_catastrophic_i,
	input wire logic acc_b_catastrophic_i,
	input wire logic service_active_i,
	input wire logic [3:0] cpu_prio_level_o,
	input wire logic user_irq_block_o,
	input wire logic preempt_allow_o,
	input wire logic acc_a_trap_o,
	input wire logic catastrophic_trap_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	property p_ready;
		psel_i && !penable_i |=> pready_o;
	endproperty
	a_ready: assert property (p_ready) else $error("no ready after setup");
	property p_upper;
		pready_o && !pwrite_i |-> prdata_o[31:16] == 16'h0000;
	endproperty
	a_upper: assert property (p_upper) else $error("upper read bits set");
	property p_load;
		cpu_prio_load_valid_i |-> ##2 cpu_prio_level_o == $past(cpu_prio_load_i, 2);
	endproperty
	a_load: assert property (p_load) else $error("level not loaded");
	property p_block;
		$stable(cpu_prio_level_o) |-> user_irq_block_o == cpu_prio_level_o[3];
	endproperty
	a_block: assert property (p_block) else $error("block mismatch");
	property p_noset;
		$rose(cpu_prio_level_o[3]) |-> $past(cpu_prio_load_valid_i, 2);
	endproperty
	a_noset: assert property (p_noset) else $error("top bit set by write");
	property p_trap;
		acc_a_trap_o |-> $past(acc_a_overflow_i);
	endproperty
	a_trap: assert property (p_trap) else $error("trap without cause");
	property p_cat;
		catastrophic_trap_o |-> $past(acc_a_catastrophic_i || acc_b_catastrophic_i);
	endproperty
	a_cat: assert property (p_cat) else $error("catastrophic without cause");
	property p_pre;
		!service_active_i |=> preempt_allow_o;
	endproperty
	a_pre: assert property (p_pre) else $error("preempt blocked");
endmodule
bind interrupt_priority_trap_flags intc_checker chk (.*);

// [interrupt_priority_trap_flags_tb_top.sv]
`timescale 1ns/1ps
module interrupt_priority_trap_flags_tb_top;
	typedef struct {logic [11:0] a; logic [15:0] w; logic [15:0] e;} row_t;
	logic clk_i = 1'b0, rst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
	logic [11:0] paddr_i = 12'h000;
	logic [31:0] pwdata_i = 32'h00000000, prdata_o;
	logic [3:0] pstrb_i = 4'hF, cpu_prio_load_i = 4'h0, cpu_prio_level_o, cause = 4'h0;
	logic cpu_prio_load_valid_i = 1'b0, timed_disable_i = 1'b0, service_active_i = 1'b0;
	logic [2:0] ext_irq_pin_i = 3'h0;
	logic [15:0] req_set_zero_i = 16'h0000, req_set_one_i = 16'h0000, req_set_two_i = 16'h0000;
	logic pready_o, pslverr_o, user_irq_block_o, preempt_allow_o, alternate_vector_select_o;
	logic acc_a_trap_o, acc_b_trap_o, catastrophic_trap_o, fire = 1'b0, err;
	logic acc_a_overflow_i, acc_b_overflow_i, acc_a_catastrophic_i, acc_b_catastrophic_i;
	logic bad_shift_i, divide_zero_i, address_error_i, stack_error_i, osc_fail_i;
	logic [15:0] rd, texp;
	int n_mismatch = 0;
	int tests_run = 0;
	row_t rows [7] = '{'{12'h000, 16'hFFFF, 16'h00E0}, '{12'h004, 16'hFFFF, 16'h0000},
		'{12'h008, 16'h7FFF, 16'h7FDE}, '{12'h00C, 16'hFFFF, 16'h8007},
		'{12'h010, 16'hFFFF, 16'h3FEF}, '{12'h014, 16'hFFFF, 16'h201F},
		'{12'h018, 16'hFFFF, 16'h0020}};
	logic [15:0] tbit [9] = '{16'h4000, 16'h2000, 16'h1000, 16'h0800, 16'h0080,
		16'h0040, 16'h0008, 16'h0004, 16'h0002};
	interrupt_priority_trap_flags DUT (.*);
	trap_source_model src (.clk_i(clk_i), .rst_i(rst_i), .fire_i(fire), .cause_i(cause),
		.trap_o({osc_fail_i, stack_error_i, address_error_i, divide_zero_i, bad_shift_i,
		acc_b_catastrophic_i, acc_a_catastrophic_i, acc_b_overflow_i, acc_a_overflow_i}));
	initial
	begin
		forever #25 clk_i = ~clk_i;
	end
	task automatic complete_run();
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic cmp(string nm, logic [15:0] e, logic [15:0] g);
		tests_run++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("[FAIL] %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic apb(logic w, logic [11:0] a, logic [15:0] d);
		int k;
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= {16'h0000, d};
		@(posedge clk_i);
		penable_i <= 1'b1;
		@(posedge clk_i);
		for (k = 0; k < 20 && pready_o !== 1'b1; k++)
			@(posedge clk_i);
		if (k == 20)
		begin
			n_mismatch++;
			complete_run();
		end
		else
		begin
			rd = prdata_o[15:0];
			err = pslverr_o;
			psel_i <= 1'b0;
			penable_i <= 1'b0;
			@(posedge clk_i);
		end
	endtask
	task automatic rdc(logic [11:0] a, logic [15:0] e);
		apb(1'b0, a, 16'h0000);
		cmp($sformatf("reg %h", a), e, rd);
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge clk_i);
	endtask
	initial
	begin
		tick(2);
		rst_i <= 1'b0;
		tick(1);
		foreach (rows[i])
		begin
			rdc(rows[i].a, 16'h0000);
			apb(1'b1, rows[i].a, rows[i].w);
			rdc(rows[i].a, rows[i].e);
			apb(1'b1, rows[i].a, 16'h0000);
			rdc(rows[i].a, 16'h0000);
		end
		apb(1'b1, 12'h01C, 16'hFFFF);
		cmp("slverr", 16'h0001, {15'h0000, err});
		rdc(12'h01C, 16'h0000);
		$display("register table done");
		apb(1'b1, 12'h008, 16'h8000);
		apb(1'b1, 12'h000, 16'h00E0);
		rdc(12'h000, 16'h0000);
		service_active_i <= 1'b1;
		tick(2);
		cmp("preempt", 16'h0000, {15'h0000, preempt_allow_o});
		service_active_i <= 1'b0;
		apb(1'b1, 12'h008, 16'h0000);
		apb(1'b1, 12'h000, 16'h00A0);
		tick(1);
		cmp("level", 16'h0005, {12'h000, cpu_prio_level_o});
		cpu_prio_load_i <= 4'hA;
		cpu_prio_load_valid_i <= 1'b1;
		tick(1);
		cpu_prio_load_valid_i <= 1'b0;
		tick(2);
		cmp("level", 16'h000A, {12'h000, cpu_prio_level_o});
		rdc(12'h004, 16'h0008);
		rdc(12'h000, 16'h0040);
		cmp("block", 16'h0001, {15'h0000, user_irq_block_o});
		apb(1'b1, 12'h004, 16'h0000);
		rdc(12'h004, 16'h0000);
		cmp("block", 16'h0000, {15'h0000, user_irq_block_o});
		apb(1'b1, 12'h00C, 16'h8000);
		tick(1);
		cmp("altvec", 16'h0001, {15'h0000, alternate_vector_select_o});
		$display("priority done");
		apb(1'b1, 12'h008, 16'h0700);
		for (int i = 0; i < 9; i++)
		begin
			cause <= i[3:0];
			fire <= 1'b1;
			tick(1);
			fire <= 1'b0;
			tick(1);
			tick(1);
			texp = (i == 0) ? 16'h0004 : (i == 1) ? 16'h0002 : (i < 4) ? 16'h0001 : 16'h0000;
			cmp("trap out", texp, {13'h0000, acc_a_trap_o, acc_b_trap_o, catastrophic_trap_o});
			rdc(12'h008, 16'h0700 | tbit[i] | (i < 6 ? 16'h0010 : 16'h0000));
			apb(1'b1, 12'h008, 16'h0700);
		end
		apb(1'b1, 12'h008, 16'h0000);
		cause <= 4'h0;
		fire <= 1'b1;
		tick(1);
		fire <= 1'b0;
		tick(2);
		cmp("trap off", 16'h0000, {13'h0000, acc_a_trap_o, acc_b_trap_o, catastrophic_trap_o});
		rdc(12'h008, 16'h0000);
		$display("traps done");
		{req_set_zero_i, req_set_one_i, req_set_two_i} <= {48{1'b1}};
		tick(1);
		{req_set_zero_i, req_set_one_i, req_set_two_i} <= 48'h000000000000;
		tick(1);
		rdc(12'h010, 16'h3FEF);
		rdc(12'h014, 16'h201F);
		rdc(12'h018, 16'h0020);
		apb(1'b1, 12'h010, 16'h0000);
		ext_irq_pin_i <= 3'h1;
		tick(8);
		rdc(12'h010, 16'h0001);
		apb(1'b1, 12'h010, 16'h0000);
		apb(1'b1, 12'h00C, 16'h0001);
		ext_irq_pin_i <= 3'h0;
		tick(8);
		rdc(12'h010, 16'h0001);
		timed_disable_i <= 1'b1;
		tick(2);
		rdc(12'h00C, 16'h4001);
		$display("flags done");
		rst_i <= 1'b1;
		tick(2);
		rst_i <= 1'b0;
		tick(1);
		rdc(12'h014, 16'h0000);
		rdc(12'h00C, 16'h4000);
		cmp("preempt", 16'h0001, {15'h0000, preempt_allow_o});
		$display("reset done");
		complete_run();
	end
endmodule
